/* File: nisem_consts.vh */
// constants for the normal interrupt signal mask block
`ifndef NISEM_CONSTS_VH
`define NISEM_CONSTS_VH

// ----------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------
`define NISEM_AW            8
`define NISEM_DW            16

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define NISEM_OFS_LINE_EN   8'h38
`define NISEM_OFS_CAP_STS   8'h40
`define NISEM_OFS_CAP_MASK  8'h44
`define NISEM_OFS_RAW_STS   8'h48
`define NISEM_OFS_GATED     8'h4C

// ----------------------------------------------------------------
// field positions of the line enable register
// ----------------------------------------------------------------
`define NISEM_BIT_FIXED0    15
`define NISEM_BIT_RSVD      14
`define NISEM_BIT_XFN_EVT   13
`define NISEM_BIT_RETUNE    12
`define NISEM_BIT_EMB_C     11
`define NISEM_BIT_EMB_B     10
`define NISEM_BIT_EMB_A     9
`define NISEM_BIT_CARD_INT  8
`define NISEM_BIT_CARD_REM  7
`define NISEM_BIT_CARD_INS  6
`define NISEM_BIT_BUF_RD    5
`define NISEM_BIT_BUF_WR    4
`define NISEM_BIT_DMA       3
`define NISEM_BIT_BLK_GAP   2
`define NISEM_BIT_XFER_DONE 1
`define NISEM_BIT_CMD_DONE  0

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define NISEM_WR_MASK       16'h3FFF
`define NISEM_RST_LINE_EN   16'h0000
`define NISEM_RST_CAP_MASK  16'h0000
`define NISEM_ZERO16        16'h0000

`endif

/* File: nisem_host_model.sv */
// host side model: counts assertions of the shared interrupt line
`timescale 1ns/1ns
`default_nettype none

module nisem_host_model
(
  input  wire logic       i_mclk,  // clock
  input  wire logic       i_rst,   // reset
  input  wire logic       i_irq,   // shared interrupt line
  output logic      [7:0] o_edges  // rising edges seen
);
  logic seen_r;
  // one line for all events, so only its rises are countable
  always_ff @(posedge i_mclk)
    if (i_rst)
    begin
      o_edges <= 8'h00;
      seen_r  <= 1'b0;
    end
    else
    begin
      o_edges <= o_edges + {7'h00, i_irq & ~seen_r};
      seen_r  <= i_irq;
    end
endmodule
`default_nettype wire

/* File: nisem_sticky.v */
// sticky capture bits with write-one-to-clear, set wins over clear
`timescale 1ns/1ns
`default_nettype none

module nisem_sticky
(
  input  wire        i_mclk,    // system clock
  input  wire        i_rst,     // synchronous reset, active high
  input  wire        i_ce,      // clock enable, freezes state when low
  input  wire [15:0] i_set,     // one-cycle set requests per bit
  input  wire [15:0] i_clr,     // one-cycle clear requests per bit
  output wire [15:0] o_sts      // sticky bits
);

  reg  [15:0] sts_r;

  // ----------------------------------------------------------------
  // per bit flops
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_bit
      always @(posedge i_mclk)
      begin
        if (i_rst)
          sts_r[g] <= 1'b0;
        else if (i_ce)
        begin
          // an event in the clearing cycle must not be lost
          if (i_set[g])
            sts_r[g] <= 1'b1;
          else if (i_clr[g])
            sts_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_sts = sts_r;

endmodule

`default_nettype wire

/* File: nisem_top.v */
// normal interrupt signal mask: enable register and interrupt line gating
//
// Function
// (RL1) each writable mask bit: 1 passes its status event, 0 masks it.
// (RL2) all enabled events share one single-bit interrupt line.
// (RL3) bit 15 is read-only zero; error enables live elsewhere.
// (RL4) bit 13 enables the extended-function event.
// (RL5) bit 12 enables the re-tuning event.
// (RL6) bits 11, 10, 9 enable embedded interrupts C, B, A.
// (RL7) bit 8 enables the card interrupt event.
// (RL8) bit 7 enables the card removal event.
// (RL9) bit 6 enables the card insertion event.
// (RL10) bits 5 and 4 enable buffer read ready and write ready.
// (RL11) bits 3 and 2 enable DMA interrupt and block gap events.
// (RL12) bits 1 and 0 enable transfer complete and command complete.
// (RL13) line is OR of status AND enable; enables never alter status.
// (RL14) reserved bit 14 reads zero and ignores writes.
`timescale 1ns/1ns
`default_nettype none
`include "nisem_consts.vh"

module nisem_top
(
  input  wire                  i_mclk,     // system clock, 10 MHz
  input  wire                  i_rst,      // synchronous reset, active high
  input  wire                  i_ce,       // clock enable, freezes state when low
  input  wire [`NISEM_AW-1:0]  i_addr,     // register byte address
  input  wire [`NISEM_DW-1:0]  i_wdata,    // register write data
  input  wire                  i_wr,       // write strobe, one cycle
  input  wire                  i_rd,       // read strobe, one cycle
  output wire [`NISEM_DW-1:0]  o_rdata,    // read data, cycle after i_rd
  input  wire [15:0]           i_nrm_sts,  // normal interrupt status bits, levels
  output wire                  o_irq,      // shared host interrupt line, level
  output wire                  o_cap_irq   // capture interrupt, level
);

  // ----------------------------------------------------------------
  // decode helper
  // ----------------------------------------------------------------
  function hit;
    input [`NISEM_AW-1:0] addr;
    input [`NISEM_AW-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [15:0]          line_en_r;
  reg  [15:0]          line_en_nxt;
  reg  [15:0]          cap_mask_r;
  reg  [15:0]          cap_mask_nxt;
  reg  [15:0]          gated_prev_r;
  reg  [`NISEM_DW-1:0] rdata_r;
  reg  [`NISEM_DW-1:0] rdata_nxt;
  wire [15:0]          gated;
  wire [15:0]          cap_set;
  wire [15:0]          cap_clr;
  wire [15:0]          cap_sts;
  wire                 wr_line_en;
  wire                 wr_cap_sts;
  wire                 wr_cap_mask;

  assign wr_line_en  = i_wr & hit(i_addr, `NISEM_OFS_LINE_EN);
  assign wr_cap_sts  = i_wr & hit(i_addr, `NISEM_OFS_CAP_STS);
  assign wr_cap_mask = i_wr & hit(i_addr, `NISEM_OFS_CAP_MASK);

  // ----------------------------------------------------------------
  // line enable register
  // ----------------------------------------------------------------
  always @*
  begin
    line_en_nxt = line_en_r;
    if (wr_line_en)
      line_en_nxt = i_wdata & `NISEM_WR_MASK; // [RL3] [RL14]
  end

  always @(posedge i_mclk)
  begin
    if (i_rst)
      line_en_r <= `NISEM_RST_LINE_EN;
    else if (i_ce)
      line_en_r <= line_en_nxt;
  end

  // ----------------------------------------------------------------
  // per event gating; status inputs are only read, never changed
  // ----------------------------------------------------------------
  assign gated[`NISEM_BIT_FIXED0]    = 1'b0; // [RL3]
  assign gated[`NISEM_BIT_RSVD]      = 1'b0; // [RL14]
  assign gated[`NISEM_BIT_XFN_EVT]   = i_nrm_sts[`NISEM_BIT_XFN_EVT]
                                     & line_en_r[`NISEM_BIT_XFN_EVT]; // [RL4]
  assign gated[`NISEM_BIT_RETUNE]    = i_nrm_sts[`NISEM_BIT_RETUNE]
                                     & line_en_r[`NISEM_BIT_RETUNE]; // [RL5]
  assign gated[`NISEM_BIT_EMB_C]     = i_nrm_sts[`NISEM_BIT_EMB_C]
                                     & line_en_r[`NISEM_BIT_EMB_C]; // [RL6]
  assign gated[`NISEM_BIT_EMB_B]     = i_nrm_sts[`NISEM_BIT_EMB_B]
                                     & line_en_r[`NISEM_BIT_EMB_B]; // [RL6]
  assign gated[`NISEM_BIT_EMB_A]     = i_nrm_sts[`NISEM_BIT_EMB_A]
                                     & line_en_r[`NISEM_BIT_EMB_A]; // [RL6]
  assign gated[`NISEM_BIT_CARD_INT]  = i_nrm_sts[`NISEM_BIT_CARD_INT]
                                     & line_en_r[`NISEM_BIT_CARD_INT]; // [RL7]
  assign gated[`NISEM_BIT_CARD_REM]  = i_nrm_sts[`NISEM_BIT_CARD_REM]
                                     & line_en_r[`NISEM_BIT_CARD_REM]; // [RL8]
  assign gated[`NISEM_BIT_CARD_INS]  = i_nrm_sts[`NISEM_BIT_CARD_INS]
                                     & line_en_r[`NISEM_BIT_CARD_INS]; // [RL9]
  assign gated[`NISEM_BIT_BUF_RD]    = i_nrm_sts[`NISEM_BIT_BUF_RD]
                                     & line_en_r[`NISEM_BIT_BUF_RD]; // [RL10]
  assign gated[`NISEM_BIT_BUF_WR]    = i_nrm_sts[`NISEM_BIT_BUF_WR]
                                     & line_en_r[`NISEM_BIT_BUF_WR]; // [RL10]
  assign gated[`NISEM_BIT_DMA]       = i_nrm_sts[`NISEM_BIT_DMA]
                                     & line_en_r[`NISEM_BIT_DMA]; // [RL11]
  assign gated[`NISEM_BIT_BLK_GAP]   = i_nrm_sts[`NISEM_BIT_BLK_GAP]
                                     & line_en_r[`NISEM_BIT_BLK_GAP]; // [RL11]
  assign gated[`NISEM_BIT_XFER_DONE] = i_nrm_sts[`NISEM_BIT_XFER_DONE]
                                     & line_en_r[`NISEM_BIT_XFER_DONE]; // [RL12]
  assign gated[`NISEM_BIT_CMD_DONE]  = i_nrm_sts[`NISEM_BIT_CMD_DONE]
                                     & line_en_r[`NISEM_BIT_CMD_DONE]; // [RL12]

  // combinational so the line follows status with no added latency
  assign o_irq = |gated; // [RL1] [RL2] [RL13]

  // ----------------------------------------------------------------
  // capture of newly signalled events
  // ----------------------------------------------------------------
  always @(posedge i_mclk)
  begin
    if (i_rst)
      gated_prev_r <= `NISEM_ZERO16;
    else if (i_ce)
      gated_prev_r <= gated;
  end

  assign cap_set = gated & ~gated_prev_r;
  assign cap_clr = wr_cap_sts ? (i_wdata & `NISEM_WR_MASK) : `NISEM_ZERO16;

  nisem_sticky i_nisem_sticky
  (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_set  (cap_set),
    .i_clr  (cap_clr),
    .o_sts  (cap_sts)
  );

  always @*
  begin
    cap_mask_nxt = cap_mask_r;
    if (wr_cap_mask)
      cap_mask_nxt = i_wdata & `NISEM_WR_MASK;
  end

  always @(posedge i_mclk)
  begin
    if (i_rst)
      cap_mask_r <= `NISEM_RST_CAP_MASK;
    else if (i_ce)
      cap_mask_r <= cap_mask_nxt;
  end

  assign o_cap_irq = |(cap_sts & cap_mask_r);

  // ----------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @*
  begin
    rdata_nxt = `NISEM_ZERO16;
    if (i_rd)
    begin
      if (hit(i_addr, `NISEM_OFS_LINE_EN))
        rdata_nxt = line_en_r & `NISEM_WR_MASK; // [RL3] [RL14]
      else if (hit(i_addr, `NISEM_OFS_CAP_STS))
        rdata_nxt = cap_sts;
      else if (hit(i_addr, `NISEM_OFS_CAP_MASK))
        rdata_nxt = cap_mask_r;
      else if (hit(i_addr, `NISEM_OFS_RAW_STS))
        rdata_nxt = i_nrm_sts;
      else if (hit(i_addr, `NISEM_OFS_GATED))
        rdata_nxt = gated;
    end
  end

  // zero outside the answer cycle while i_ce is high; a low i_ce holds the last read data
  always @(posedge i_mclk)
  begin
    if (i_rst)
      rdata_r <= `NISEM_ZERO16;
    else if (i_ce)
      rdata_r <= rdata_nxt;
  end

  assign o_rdata = rdata_r;

endmodule

`default_nettype wire

/* File: nisem_top_asserts.sv */
// checker for the enable register and the shared interrupt line
`timescale 1ns/1ns
`default_nettype none
`include "nisem_consts.vh"

module nisem_asserts
(
  input wire logic [`NISEM_AW-1:0] i_addr,    // byte address
  input wire logic [`NISEM_DW-1:0] i_wdata,   // write data
  input wire logic                 i_mclk,    // clock
  input wire logic                 i_rst,     // reset
  input wire logic                 i_ce,      // clock enable
  input wire logic                 i_wr,      // write strobe
  input wire logic                 i_rd,      // read strobe
  input wire logic [`NISEM_DW-1:0] o_rdata,   // read data
  input wire logic [15:0]          i_nrm_sts, // status levels
  input wire logic                 o_irq,     // interrupt line
  input wire logic                 o_cap_irq  // capture interrupt
);
  // ----------------------------------------------------------------
  // shadow enable, so the line can be judged without the body
  // ----------------------------------------------------------------
  logic [15:0] en_r;
  wire         rd = i_rd & i_ce;
  wire         wen = i_wr & i_ce & (i_addr == `NISEM_OFS_LINE_EN);
  always_ff @(posedge i_mclk)
    if (i_rst)
      en_r <= 16'h0000;
    else if (wen)
      en_r <= i_wdata & 16'h3FFF;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_line_gating:
    assert property (o_irq == |(i_nrm_sts & en_r)) else $error("irq line mismatch");
  a_top_bits_dead:
    assert property ((i_nrm_sts & 16'h3FFF) == 16'h0000 |-> !o_irq) else $error("top bits irq");
  a_enable_effect:
    assert property (wen |=> o_irq == |(i_nrm_sts & $past(i_wdata) & 16'h3FFF))
      else $error("enable write effect");
  a_enable_readback:
    assert property (rd && i_addr == `NISEM_OFS_LINE_EN |=> o_rdata == $past(en_r))
      else $error("enable readback");
  a_rdata_idle:
    assert property (i_ce && !i_rd |=> o_rdata == 16'h0000) else $error("rdata not idle");
  a_unmapped_zero:
    assert property (rd && i_addr == 8'h10 |=> o_rdata == 16'h0000) else $error("unmapped read");
  a_raw_status:
    assert property (rd && i_addr == `NISEM_OFS_RAW_STS |=> o_rdata == $past(i_nrm_sts))
      else $error("raw status altered");
  a_gated_status:
    assert property (rd && i_addr == `NISEM_OFS_GATED |=> o_rdata == $past(i_nrm_sts & en_r))
      else $error("gated status");

  c_irq_rise: cover property ($rose(o_irq));
  c_cap_irq:  cover property ($rose(o_cap_irq));
  c_en_read:  cover property (rd && i_addr == `NISEM_OFS_LINE_EN);
endmodule

bind nisem_top nisem_asserts i_nisem_asserts (.i_addr(i_addr), .i_wdata(i_wdata),
  .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_nrm_sts(i_nrm_sts), .o_irq(o_irq), .o_cap_irq(o_cap_irq));
`default_nettype wire

/* File: normal_interrupt_signal_mask_tb_top.sv */
// testbench for the normal interrupt signal mask block
`timescale 1ns/1ns
`default_nettype none

module normal_interrupt_signal_mask_tb_top;
  logic        i_mclk = 0, i_rst = 1, i_ce = 1, i_wr = 0, i_rd = 0;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, i_nrm_sts = 16'h0000;
  wire  [15:0] o_rdata;
  wire         o_irq, o_cap_irq;
  wire  [7:0]  edges;
  int          bad_count = 0, total_checks = 0;

  always #50 i_mclk = ~i_mclk;

  nisem_top i_nisem_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_nrm_sts(i_nrm_sts), .o_irq(o_irq), .o_cap_irq(o_cap_irq));
  nisem_host_model i_nisem_host_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_irq(o_irq),
    .o_edges(edges));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(nm, e, o_rdata);
  endtask
  task automatic sts(input logic [15:0] v, input logic e);
    @(posedge i_mclk);
    i_nrm_sts <= v;
    #1 chk1("irq", e, o_irq);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog, far beyond the under 150 cycles the tests need
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    bad_count++;
    finish_test();
  end

  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    rchk("en_reset", 8'h38, 16'h0000);
    wr(8'h38, 16'hFFFF);
    rchk("en_rw", 8'h38, 16'h3FFF);
    sts(16'hC000, 1'b0);
    for (int i = 0; i < 14; i++)
    begin
      wr(8'h38, 16'h0001 << i);
      sts(~(16'h0001 << i), 1'b0);
      sts(16'h0001 << i, 1'b1);
      rchk("raw", 8'h48, 16'h0001 << i);
    end
    wr(8'h38, 16'h0101);
    sts(16'h0180, 1'b1);
    rchk("gated", 8'h4C, 16'h0100);
    chk("irq_edges", 16'h000F, {8'h00, edges});
    wr(8'h10, 16'hFFFF);
    rchk("unmapped", 8'h10, 16'h0000);
    rchk("en_kept", 8'h38, 16'h0101);
    // a write while the clock enable is low must not be taken
    @(posedge i_mclk);
    i_ce <= 1'b0;
    wr(8'h38, 16'h0000);
    i_ce <= 1'b1;
    rchk("en_frozen", 8'h38, 16'h0101);
    // capture: every gated rise of the sweep above was caught once
    sts(16'h0000, 1'b0);
    rchk("cap_hist", 8'h40, 16'h3FFF);
    wr(8'h40, 16'hFFFF);
    wr(8'h38, 16'h0001);
    wr(8'h44, 16'h0001);
    sts(16'h0001, 1'b1);
    @(posedge i_mclk);
    #1 chk1("cap_irq", 1'b1, o_cap_irq);
    wr(8'h44, 16'h0000);
    #1 chk1("cap_masked", 1'b0, o_cap_irq);
    rchk("cap_sts", 8'h40, 16'h0001);
    wr(8'h40, 16'h0001);
    rchk("cap_clr", 8'h40, 16'h0000);
    wr(8'h44, 16'h0001);
    #1 chk1("cap_off", 1'b0, o_cap_irq);
    // event and clear at the same edge: the set must win
    sts(16'h0000, 1'b0);
    @(posedge i_mclk);
    i_nrm_sts <= 16'h0001;
    i_addr <= 8'h40;
    i_wdata <= 16'h0001;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1 chk1("cap_set_wins_irq", 1'b1, o_cap_irq);
    rchk("cap_set_wins", 8'h40, 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
